// ===== rtl/adcc_pkg.sv
// constants, field layout and state encoding of the a/d conversion control
package adcc_pkg;

  // ------------------------------------------------------------
  // bus geometry and register offsets
  // ------------------------------------------------------------
  localparam int unsigned ADCC_DATA_W = 32;
  localparam int unsigned ADCC_ADDR_W = 4;
  localparam logic [3:0] ADCC_OFS_CONTROL = 4'h0;
  localparam logic [3:0] ADCC_OFS_RES_HIGH = 4'h4;
  localparam logic [3:0] ADCC_OFS_RES_LOW = 4'h8;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int unsigned ADCC_BIT_BUSY = 0;
  localparam int unsigned ADCC_BIT_DIV16 = 1;
  localparam int unsigned ADCC_BIT_ROUTE = 2;
  localparam int unsigned ADCC_BIT_DIFF = 3;
  localparam int unsigned ADCC_CHAN_LSB = 4;
  localparam int unsigned ADCC_CHAN_MSB = 7;
  localparam logic [7:1] ADCC_FIELDS_RESET = 7'h00;
  localparam logic ADCC_BUSY_RESET = 1'b0;

  // ------------------------------------------------------------
  // result layout
  // ------------------------------------------------------------
  localparam int unsigned ADCC_RESULT_W = 10;
  localparam int unsigned ADCC_RES_LOW_LSB = 6;
  localparam logic [9:0] ADCC_SAR_FIRST = 10'h200;

  // ------------------------------------------------------------
  // conversion timing in converter clocks
  // ------------------------------------------------------------
  localparam logic [3:0] ADCC_SAMPLE_TICKS = 4'h3;
  localparam logic [3:0] ADCC_AZERO_TICKS = 4'h1;
  localparam logic [3:0] ADCC_CONVERT_TICKS = 4'ha;
  localparam logic [3:0] ADCC_LOAD_TICKS = 4'h1;
  localparam logic [3:0] ADCC_DIV16_LAST = 4'hf;

  // ------------------------------------------------------------
  // sequencer states, gray from idle through load; the return from load to idle changes all three bits
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b000,
    ADCC_ARMED = 3'b001,
    ADCC_SAMPLE = 3'b011,
    ADCC_AZERO = 3'b010,
    ADCC_CONVERT = 3'b110,
    ADCC_LOAD = 3'b111
  } adcc_state_e;

endpackage

// ===== rtl/adcc_core_if.sv
// interface joining the sequencer to its prescaler and approximation register
interface adcc_core_if;
  import adcc_pkg::*;

  logic run;
  logic div16;
  logic tick;
  logic sar_start;
  logic sar_step;
  logic comp;
  logic [ADCC_RESULT_W-1:0] trial;

  modport prescale (input run, input div16, output tick);
  modport sar (input sar_start, input sar_step, input comp, output trial);
  modport ctrl (
    output run, output div16, output sar_start, output sar_step,
    output comp, input tick, input trial
  );
endinterface

// ===== rtl/adcc_prescale.sv
// converter clock prescaler producing one tick per converter clock
module adcc_prescale (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // sequencer side
  adcc_core_if.prescale pif
);
  import adcc_pkg::*;

  logic [3:0] div_cnt_reg;
  logic [3:0] div_cnt_next;
  logic tick_reg;
  logic tick_next;

  // held in reset while stopped so each start begins a fresh period
  always_comb begin
    div_cnt_next = '0;
    tick_next = 1'b0;
    if (pif.run) begin
      div_cnt_next = 4'(div_cnt_reg + 4'h1);
      tick_next = !pif.div16 || (div_cnt_reg == ADCC_DIV16_LAST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign pif.tick = tick_reg && pif.run;
endmodule

// ===== rtl/adcc_sar.sv
// successive-approximation register, one decision per step, msb first
module adcc_sar (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // sequencer side
  adcc_core_if.sar sif
);
  import adcc_pkg::*;

  logic [ADCC_RESULT_W-1:0] trial_reg;
  logic [ADCC_RESULT_W-1:0] trial_next;
  logic [ADCC_RESULT_W-1:0] mask_reg;
  logic [ADCC_RESULT_W-1:0] mask_next;

  // comp high means the input is at or above the trial level: keep the bit
  always_comb begin
    trial_next = trial_reg;
    mask_next = mask_reg;
    if (sif.sar_start) begin
      trial_next = ADCC_SAR_FIRST;
      mask_next = ADCC_SAR_FIRST;
    end else if (sif.sar_step) begin
      trial_next = (sif.comp ? trial_reg : (trial_reg & ~mask_reg))
                   | (mask_reg >> 1);
      mask_next = mask_reg >> 1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trial_reg <= '0;
      mask_reg <= '0;
    end else begin
      trial_reg <= trial_next;
      mask_reg <= mask_next;
    end
  end

  assign sif.trial = trial_reg;
endmodule

// ===== rtl/adcc_top.sv
// a/d conversion control: registers, sequencer and analog routing controls
module adcc_top (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  // avalon-mm slave
  input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [adcc_pkg::ADCC_DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [adcc_pkg::ADCC_DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // core power state
  input wire logic POWER_SAVE_I,
  // converter macro
  input wire logic COMP_I,
  output logic CONV_POWER_O,
  output logic SAMPLE_O,
  output logic AUTOZERO_O,
  output logic [adcc_pkg::ADCC_RESULT_W-1:0] DAC_CODE_O,
  // input multiplexor and routing
  output logic [3:0] CHANNEL_O,
  output logic DIFFERENTIAL_O,
  output logic CHANNEL_ENABLE_O,
  output logic ROUTED_OUT_EN_O,
  output logic ROUTED_MINUS_EN_O,
  output logic CONVERTER_IN_EXT_O
);
  import adcc_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  adcc_core_if core ();

  logic ack_reg;
  logic ack_next;
  logic [ADCC_DATA_W-1:0] rdata_reg;
  logic [ADCC_DATA_W-1:0] rdata_next;
  logic wr_fire;
  logic wr_control;
  logic wr_res_high;
  logic wr_res_low;

  logic [7:1] fields_reg;
  logic [7:1] fields_next;
  logic busy_reg;
  logic busy_next;
  logic [7:0] control_view;

  adcc_state_e state_reg;
  adcc_state_e state_next;
  logic [3:0] phase_reg;
  logic [3:0] phase_next;
  logic done;

  logic [7:0] res_high_reg;
  logic [7:0] res_high_next;
  logic [1:0] res_low_reg;
  logic [1:0] res_low_next;

  logic route;
  logic diff;

  // ------------------------------------------------------------
  // bus slave: one wait cycle for every access
  // ------------------------------------------------------------
  // the wait cycle lets read data come out of a register
  always_comb begin
    ack_next = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;

  // a write takes effect only at the edge that ends its wait
  assign wr_fire = AVS_WRITE_I && ack_reg && AVS_BYTEENABLE_I[0];
  assign wr_control = wr_fire && (AVS_ADDRESS_I == ADCC_OFS_CONTROL);
  assign wr_res_high = wr_fire && (AVS_ADDRESS_I == ADCC_OFS_RES_HIGH);
  assign wr_res_low = wr_fire && (AVS_ADDRESS_I == ADCC_OFS_RES_LOW);

  assign control_view = {fields_reg, busy_reg};

  // unmapped offsets read as zero and ignore writes
  always_comb begin
    rdata_next = rdata_reg;
    if (AVS_READ_I && !ack_reg) begin
      rdata_next = '0;
      if (AVS_ADDRESS_I == ADCC_OFS_CONTROL) begin
        rdata_next[7:0] = control_view;
      end else if (AVS_ADDRESS_I == ADCC_OFS_RES_HIGH) begin
        rdata_next[7:0] = res_high_reg;
      end else if (AVS_ADDRESS_I == ADCC_OFS_RES_LOW) begin
        rdata_next[7:ADCC_RES_LOW_LSB] = res_low_reg;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign AVS_READDATA_O = rdata_reg;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_comb begin
    fields_next = fields_reg;
    busy_next = busy_reg;
    if (wr_control) begin
      if (!busy_reg) begin
        fields_next = AVS_WRITEDATA_I[7:1];
        busy_next = AVS_WRITEDATA_I[ADCC_BIT_BUSY];
      end else if (!AVS_WRITEDATA_I[ADCC_BIT_BUSY]) begin
        busy_next = 1'b0;
      end
    end
    // a finished conversion ends here, as a write of zero ends a running one; no write can set busy then
    if (done) begin
      busy_next = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      fields_reg <= ADCC_FIELDS_RESET;
      busy_reg <= ADCC_BUSY_RESET;
    end else begin
      fields_reg <= fields_next;
      busy_reg <= busy_next;
    end
  end

  assign route = fields_reg[ADCC_BIT_ROUTE];
  assign diff = fields_reg[ADCC_BIT_DIFF];

  // ------------------------------------------------------------
  // prescaler and approximation register
  // ------------------------------------------------------------
  // the prescaler runs only for a busy, awake converter
  assign core.run = busy_reg && !POWER_SAVE_I;
  assign core.div16 = fields_reg[ADCC_BIT_DIV16];
  // comparator belongs to the converter macro on this same clock
  assign core.comp = COMP_I;

  adcc_prescale u_prescale (
    .clk_i(CLOCK_I),
    .srst_i(SRST_I),
    .pif(core.prescale)
  );

  adcc_sar u_sar (
    .clk_i(CLOCK_I),
    .srst_i(SRST_I),
    .sif(core.sar)
  );

  // ------------------------------------------------------------
  // conversion sequencer, advanced once per converter clock
  // ------------------------------------------------------------
  assign done = (state_reg == ADCC_LOAD) && core.tick
                && (phase_reg == ADCC_LOAD_TICKS) && busy_reg
                && !POWER_SAVE_I;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    core.sar_start = 1'b0;
    core.sar_step = 1'b0;
    case (state_reg)
      ADCC_IDLE: begin
        if (busy_reg) begin
          state_next = ADCC_ARMED;
        end
      end
      ADCC_ARMED: begin
        if (core.tick) begin
          state_next = ADCC_SAMPLE;
          phase_next = 4'h1;
          core.sar_start = 1'b1;
        end
      end
      ADCC_SAMPLE: begin
        if (core.tick) begin
          if (phase_reg == ADCC_SAMPLE_TICKS) begin
            state_next = ADCC_AZERO;
            phase_next = 4'h1;
          end else begin
            phase_next = 4'(phase_reg + 4'h1);
          end
        end
      end
      ADCC_AZERO: begin
        if (core.tick) begin
          if (phase_reg == ADCC_AZERO_TICKS) begin
            state_next = ADCC_CONVERT;
            phase_next = 4'h1;
          end else begin
            phase_next = 4'(phase_reg + 4'h1);
          end
        end
      end
      ADCC_CONVERT: begin
        if (core.tick) begin
          core.sar_step = 1'b1;
          if (phase_reg == ADCC_CONVERT_TICKS) begin
            state_next = ADCC_LOAD;
            phase_next = 4'h1;
          end else begin
            phase_next = 4'(phase_reg + 4'h1);
          end
        end
      end
      ADCC_LOAD: begin
        if (done) begin
          state_next = ADCC_IDLE;
          phase_next = 4'h0;
        end
      end
      default: begin
        state_next = ADCC_IDLE;
        phase_next = 4'h0;
      end
    endcase
    // power-save throws away the partial conversion; exit resamples
    if (busy_reg && POWER_SAVE_I) begin
      state_next = ADCC_ARMED;
      phase_next = 4'h0;
    end
    // software abort; a later write of one begins from the start
    if (!busy_next && !done) begin
      state_next = ADCC_IDLE;
      phase_next = 4'h0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      state_reg <= ADCC_IDLE;
      phase_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
    end
  end

  // ------------------------------------------------------------
  // result registers
  // ------------------------------------------------------------
  // no reset: contents are undefined until written or converted
  always_comb begin
    res_high_next = res_high_reg;
    res_low_next = res_low_reg;
    if (wr_res_high) begin
      res_high_next = AVS_WRITEDATA_I[7:0];
    end
    if (wr_res_low) begin
      res_low_next = AVS_WRITEDATA_I[7:ADCC_RES_LOW_LSB];
    end
    // the converter wins over a software write on the same edge
    if (done) begin
      res_high_next = core.trial[9:2];
      res_low_next = core.trial[1:0];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    res_high_reg <= res_high_next;
    res_low_reg <= res_low_next;
  end

  // ------------------------------------------------------------
  // converter and routing controls
  // ------------------------------------------------------------
  assign CONV_POWER_O = busy_reg && !POWER_SAVE_I;
  // the input switch closes only while sampling
  assign SAMPLE_O = (state_reg == ADCC_SAMPLE) && !POWER_SAVE_I;
  assign AUTOZERO_O = (state_reg == ADCC_AZERO) && !POWER_SAVE_I;
  assign DAC_CODE_O = core.trial;

  assign CHANNEL_O = fields_reg[ADCC_CHAN_MSB:ADCC_CHAN_LSB];
  assign DIFFERENTIAL_O = diff;
  // routed mode keeps the path live while idle so it can settle
  assign CHANNEL_ENABLE_O = route || CONV_POWER_O;
  assign ROUTED_OUT_EN_O = route;
  assign ROUTED_MINUS_EN_O = route && diff;
  assign CONVERTER_IN_EXT_O = route;
endmodule

// ===== verif/adcc_analog_model.sv
// behavioural analog front end: held input level and comparator
module adcc_analog_model (
  // clock
  input wire logic clk_i,
  // analog level and converter controls
  input wire logic [9:0] level_i,
  input wire logic sample_i,
  input wire logic [9:0] dac_i,
  // comparator
  output logic comp_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] held_reg = 10'h000;
  // the switch is closed only while sampling; later moves are unseen
  always @(posedge clk_i) begin
    if (sample_i) held_reg <= level_i;
  end
  // only the analog level is driven; routed pins are left undriven here
  assign comp_o = held_reg >= dac_i;
endmodule

// ===== verif/adcc_top_checker.sv
// port-level assertions of the conversion control
module adcc_top_checker (
  // clock, reset and bus
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // converter and routing
  input wire logic POWER_SAVE_I,
  input wire logic CONV_POWER_O,
  input wire logic SAMPLE_O,
  input wire logic AUTOZERO_O,
  input wire logic [3:0] CHANNEL_O,
  input wire logic DIFFERENTIAL_O,
  input wire logic CHANNEL_ENABLE_O,
  input wire logic ROUTED_OUT_EN_O,
  input wire logic CONVERTER_IN_EXT_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  // length of the current sample phase in main clocks
  logic [7:0] run_reg, run_next;
  always_comb run_next = SAMPLE_O ? run_reg + 8'h01 : 8'h00;
  always_ff @(posedge CLOCK_I) run_reg <= SRST_I ? 8'h00 : run_next;

  a_route_keeps: assert property (
    ROUTED_OUT_EN_O |-> CHANNEL_ENABLE_O && CONVERTER_IN_EXT_O)
    else $error("routing set without enabled path");
  a_input_pin: assert property (
    CONVERTER_IN_EXT_O == ROUTED_OUT_EN_O)
    else $error("converter input pin not tied to routing");
  a_idle_dark: assert property (
    !CONV_POWER_O |-> !SAMPLE_O && !AUTOZERO_O &&
      CHANNEL_ENABLE_O == ROUTED_OUT_EN_O)
    else $error("converter active while idle");
  a_halt_off: assert property (
    POWER_SAVE_I [*3] |-> !CONV_POWER_O && !SAMPLE_O)
    else $error("converter powered in power save");
  a_sample_len: assert property (
    $fell(SAMPLE_O) && CONV_POWER_O && !$past(POWER_SAVE_I) |->
      AUTOZERO_O && (run_reg == 8'h03 || run_reg == 8'h30))
    else $error("sample phase of wrong length");
  a_start_sample: assert property (
    $rose(CONV_POWER_O) |-> ##[1:20] SAMPLE_O)
    else $error("sampling did not begin after start");
  a_fields_frozen: assert property (
    CONV_POWER_O && $past(CONV_POWER_O) |->
      $stable(CHANNEL_O) && $stable(DIFFERENTIAL_O) &&
      $stable(ROUTED_OUT_EN_O))
    else $error("settings changed during conversion");
  a_wait_once: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=>
      !AVS_WAITREQUEST_O)
    else $error("wait request longer than one cycle");
  a_low_zeros: assert property (
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h8 |->
      AVS_READDATA_O[5:0] == 6'h00 && AVS_READDATA_O[31:8] == 24'h0)
    else $error("low result padding not zero");
endmodule

bind adcc_top adcc_top_checker u_adcc_chk (.CLOCK_I, .SRST_I,
  .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O,
  .AVS_WAITREQUEST_O, .POWER_SAVE_I, .CONV_POWER_O, .SAMPLE_O,
  .AUTOZERO_O, .CHANNEL_O, .DIFFERENTIAL_O, .CHANNEL_ENABLE_O,
  .ROUTED_OUT_EN_O, .CONVERTER_IN_EXT_O);

// ===== verif/adcc_top_tb.sv
// self-checking testbench of the conversion control
module adcc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adcc_pkg::*;
  typedef struct packed {logic [7:0] ctrl; logic [9:0] lev;} adcc_row_s;
  logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, psave = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'h1, chan;
  logic [31:0] wdata = 32'h0, rdata;
  logic [9:0] level = 10'h000, dac, s_cnt = 0, z_cnt = 0, t_cnt = 0;
  logic waitreq, comp, cpow, samp, azero, diff, chen, rout, inext, rminus;
  logic az_seen = 1'b0;
  int n_fail = 0, checked = 0, cyc = 0;
  // ordinary cases: settings byte and analog level
  // only rows with bit 1 set keep the converter clock legal at 10 mhz;
  // the divide-by-1 rows check the digital sequencing alone
  adcc_row_s rows [5] = '{{8'h30, 10'h2a5}, {8'h5a, 10'h155},
    {8'hc4, 10'h3ff}, {8'h7c, 10'h000}, {8'h06, 10'h001}};

  adcc_top dut (.CLOCK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .POWER_SAVE_I(psave), .COMP_I(comp),
    .CONV_POWER_O(cpow), .SAMPLE_O(samp), .AUTOZERO_O(azero),
    .DAC_CODE_O(dac), .CHANNEL_O(chan), .DIFFERENTIAL_O(diff),
    .CHANNEL_ENABLE_O(chen), .ROUTED_OUT_EN_O(rout),
    .ROUTED_MINUS_EN_O(rminus), .CONVERTER_IN_EXT_O(inext));
  adcc_analog_model u_front (.clk_i(clk), .level_i(level),
    .sample_i(samp), .dac_i(dac), .comp_o(comp));

  initial forever #50 clk = ~clk;
  // phase lengths seen at the converter, in main clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (samp) s_cnt++;
    if (azero) begin
      z_cnt++;
      az_seen = 1'b1;
    end
    if (cpow && !samp && !azero && az_seen) t_cnt++;
    if (cyc == 20000) begin
      n_fail++;
      $display("unexpected cycles: expected below %0d seen %0d", 20000, cyc);
      summarize();
    end
  end

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    // a fresh edge keeps a released strobe from rising in the same step
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    // waitreq and read data are the values that stood before this edge
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(string n, logic [9:0] e, logic [9:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(string n, logic [3:0] a, logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk_reg(n, e, q);
  endtask
  task automatic wait_done;
    logic [7:0] q;
    q = 8'h01;
    // a hang here is ended by the cycle ceiling
    while (q[0] !== 1'b0) bus(1'b0, ADCC_OFS_CONTROL, 8'h00, q);
  endtask
  task automatic conv(input adcc_row_s r);
    level <= r.lev;
    {s_cnt, z_cnt, t_cnt, az_seen} = '0;
    if (r.ctrl[2]) begin
      wr8(ADCC_OFS_CONTROL, r.ctrl & 8'hfe);
      repeat (5) @(posedge clk);
      chk_pin("idle route", 10'h006, {7'h0, chen, inext, cpow});
    end
    wr8(ADCC_OFS_CONTROL, r.ctrl | 8'h01);
    @(negedge clk);
    chk_pin("pins", {1'b0, &r.ctrl[3:2], r.ctrl[7:2], r.ctrl[2], 1'b1},
      {1'b0, rminus, chan, diff, rout, inext, cpow});
    wait_done;
    rchk("high", ADCC_OFS_RES_HIGH, r.lev[9:2]);
    rchk("low", ADCC_OFS_RES_LOW, {r.lev[1:0], 6'h00});
    rchk("ctrl", ADCC_OFS_CONTROL, r.ctrl & 8'hfe);
    chk_pin("sample", r.ctrl[1] ? 10'h030 : 10'h003, s_cnt);
    chk_pin("azero", r.ctrl[1] ? 10'h010 : 10'h001, z_cnt);
    chk_pin("convert", r.ctrl[1] ? 10'h0b0 : 10'h00b, t_cnt);
    chk_pin("idle", {8'h0, r.ctrl[2], 1'b0}, {8'h0, chen, cpow});
  endtask
  task automatic summarize;
    $display("counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) conv(rows[i]);
    $display("test table done");
    wr8(ADCC_OFS_RES_HIGH, 8'h5a);
    rchk("high", ADCC_OFS_RES_HIGH, 8'h5a);
    wr8(ADCC_OFS_RES_LOW, 8'hff);
    rchk("low", ADCC_OFS_RES_LOW, 8'hc0);
    be <= 4'h0;
    wr8(ADCC_OFS_RES_HIGH, 8'h11);
    be <= 4'h1;
    rchk("high", ADCC_OFS_RES_HIGH, 8'h5a);
    wr8(4'hc, 8'hff);
    rchk("unmapped", 4'hc, 8'h00);
    $display("test registers done");
    wr8(ADCC_OFS_CONTROL, 8'h33);
    wr8(ADCC_OFS_CONTROL, 8'hcd);
    rchk("ctrl", ADCC_OFS_CONTROL, 8'h33);
    wait (samp === 1'b1);
    level <= 10'h0f0;
    wr8(ADCC_OFS_CONTROL, 8'h32);
    wr8(ADCC_OFS_CONTROL, 8'h33);
    wait_done;
    rchk("high", ADCC_OFS_RES_HIGH, 8'h3c);
    $display("test protect restart done");
    wr8(ADCC_OFS_CONTROL, 8'h01);
    wait (samp === 1'b1);
    wr8(ADCC_OFS_CONTROL, 8'h00);
    @(negedge clk);
    chk_pin("abort", 10'h000, {6'h0, cpow, samp, azero, chen});
    $display("test abort done");
    level <= 10'h2c3;
    wr8(ADCC_OFS_CONTROL, 8'h01);
    wait (samp === 1'b1);
    @(posedge clk);
    psave <= 1'b1;
    level <= 10'h1e1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk_pin("halt", 10'h000, {8'h0, cpow, samp});
    @(posedge clk);
    psave <= 1'b0;
    wait_done;
    rchk("high", ADCC_OFS_RES_HIGH, 8'h78);
    rchk("low", ADCC_OFS_RES_LOW, 8'h40);
    $display("test power save done");
    wr8(ADCC_OFS_CONTROL, 8'h97);
    wait (samp === 1'b1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rchk("ctrl", ADCC_OFS_CONTROL, 8'h00);
    @(negedge clk);
    chk_pin("reset", 10'h000, {7'h0, cpow, chen, rout});
    $display("test reset done");
    summarize();
  end
endmodule
